// [dv/iorm_bank_bench.sv]
// testbench: register bank driven through the core model
`timescale 1ns/100ps
module iorm_bank_bench;
  localparam iorm_pkg::iorm_access_e K_IO = iorm_pkg::IORM_ACC_IO;
  localparam iorm_pkg::iorm_access_e K_DT = iorm_pkg::IORM_ACC_DATA;
  localparam iorm_pkg::iorm_access_e K_BS = iorm_pkg::IORM_ACC_BIT_SET;
  localparam iorm_pkg::iorm_access_e K_BC = iorm_pkg::IORM_ACC_BIT_CLEAR;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] ev = 4'h0;
  logic [7:0] status_value = 8'h00;
  logic [4:0] pin_level = 5'h00;
  logic access_valid, write_enable, access_hit, timer_irq_request, ext_irq_request, hit;
  iorm_pkg::iorm_access_e access_kind;
  logic [7:0] access_address, write_data, read_data, cpu_status, port_b_output, nvm_control, watchdog_control, rd;
  logic [2:0] access_bit;
  int error_cnt = 0;
  int cmp_count = 0;
  always #2 sys_clk = ~sys_clk;
  iorm_core_model u_iorm_core_model (.sys_clk(sys_clk), .access_valid(access_valid), .access_kind(access_kind),
    .access_address(access_address), .access_bit(access_bit), .write_enable(write_enable),
    .write_data(write_data), .read_data(read_data), .access_hit(access_hit));
  iorm_bank u_iorm_bank (.sys_clk(sys_clk), .reset(reset), .access_valid(access_valid), .access_kind(access_kind),
    .access_address(access_address), .access_bit(access_bit), .write_enable(write_enable),
    .write_data(write_data), .read_data(read_data), .access_hit(access_hit), .status_load(ev[3]),
    .status_value(status_value), .stack_load(1'b0), .stack_value(8'h00), .port_b_pin_level(pin_level),
    .timer_overflow_event(ev[0]), .ext_irq0_event(ev[1]), .external_reset_seen(ev[2]), .timer_count_load(1'b0),
    .timer_count_value(8'h00), .cpu_status(cpu_status), .stack_pointer_low(), .port_b_output(port_b_output),
    .port_b_direction(), .nvm_control(nvm_control), .nvm_data(), .nvm_address(),
    .watchdog_control(watchdog_control), .timer_count(), .timer_control(), .mcu_control(), .timer_irq_mask(),
    .ext_irq_mask(), .timer_irq_request(timer_irq_request), .ext_irq_request(ext_irq_request));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input iorm_pkg::iorm_access_e k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    u_iorm_core_model.access(k, a, b, 1'b1, d, rd, hit);
  endtask
  task automatic rd_chk(input iorm_pkg::iorm_access_e k, input logic [7:0] a, input logic [7:0] exp, input logic eh);
    u_iorm_core_model.access(k, a, 3'h0, 1'b0, 8'h00, rd, hit);
    check(rd, exp);
    check({7'h00, hit}, {7'h00, eh});
  endtask
  // one-cycle pulse on the selected hardware event lines
  task automatic pulse(input logic [3:0] m, input logic [7:0] v);
    @(posedge sys_clk);
    ev <= m;
    status_value <= v;
    @(posedge sys_clk);
    ev <= 4'h0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    rd_chk(K_IO, 8'h34, 8'h01, 1'b1);
    rd_chk(K_IO, 8'h3F, 8'h00, 1'b1);
    pulse(4'h8, 8'hA5);
    rd_chk(K_DT, 8'h5F, 8'hA5, 1'b1);
    pulse(4'h4, 8'h00);
    rd_chk(K_DT, 8'h54, 8'h03, 1'b1);
  endtask
  task automatic t_alias;
    logic [7:0] addr [7] = '{8'h17, 8'h1D, 8'h1E, 8'h32, 8'h33, 8'h35, 8'h3D};
    logic [7:0] val [7] = '{8'h15, 8'hC3, 8'h5A, 8'hA7, 8'h05, 8'h31, 8'h5A};
    for (int i = 0; i < 7; i++) begin
      wr(K_IO, addr[i], 3'h0, val[i]);
      rd_chk(K_DT, addr[i] + 8'h20, val[i], 1'b1);
    end
    wr(K_DT, 8'h5F, 3'h0, 8'h81);
    check(cpu_status, 8'h81);
    rd_chk(K_IO, 8'h3F, 8'h81, 1'b1);
  endtask
  task automatic t_flags;
    wr(K_IO, 8'h39, 3'h0, 8'h02);
    wr(K_IO, 8'h3B, 3'h0, 8'h40);
    pulse(4'h3, 8'h00);
    check({6'h00, ext_irq_request, timer_irq_request}, 8'h03);
    rd_chk(K_IO, 8'h38, 8'h02, 1'b1);
    rd_chk(K_IO, 8'h3A, 8'h40, 1'b1);
    wr(K_IO, 8'h38, 3'h0, 8'h00);
    rd_chk(K_IO, 8'h38, 8'h02, 1'b1);
    wr(K_IO, 8'h38, 3'h0, 8'h02);
    wr(K_DT, 8'h5A, 3'h0, 8'h40);
    check({6'h00, ext_irq_request, timer_irq_request}, 8'h00);
    rd_chk(K_IO, 8'h38, 8'h00, 1'b1);
  endtask
  task automatic t_bitops;
    wr(K_IO, 8'h18, 3'h0, 8'h11);
    wr(K_BS, 8'h18, 3'h2, 8'h00);
    check(port_b_output, 8'h15);
    wr(K_BC, 8'h18, 3'h0, 8'h00);
    check(port_b_output, 8'h14);
    for (int b = 0; b < 3; b++) begin
      wr(K_BS, 8'h1C, 3'(b), 8'h00);
      check(nvm_control, 8'((2 << b) - 1));
    end
    wr(K_BC, 8'h1C, 3'h1, 8'h00);
    check(nvm_control, 8'h05);
    wr(K_IO, 8'h1C, 3'h0, 8'h00);
    rd_chk(K_IO, 8'h1C, 8'h00, 1'b1);
    wr(K_BS, 8'h21, 3'h0, 8'h00);
    check({7'h00, hit}, 8'h00);
    check(watchdog_control, 8'h00);
    // a wrongly accepted clear would write the set flag back as one and lose it
    pulse(4'h1, 8'h00);
    wr(K_BC, 8'h38, 3'h0, 8'h00);
    check({7'h00, hit}, 8'h00);
    rd_chk(K_IO, 8'h38, 8'h02, 1'b1);
  endtask
  task automatic t_reserved;
    rd_chk(K_IO, 8'h3E, 8'h00, 1'b0);
    rd_chk(K_IO, 8'h20, 8'h00, 1'b0);
    rd_chk(K_DT, 8'h60, 8'h00, 1'b0);
    rd_chk(K_DT, 8'h1F, 8'h00, 1'b0);
    rd_chk(K_IO, 8'h40, 8'h00, 1'b0);
    @(posedge sys_clk);
    pin_level <= 5'h13;
    repeat (5) @(posedge sys_clk);
    rd_chk(K_DT, 8'h36, 8'h13, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset_values;
    t_alias;
    t_flags;
    t_bitops;
    t_reserved;
    end_sim;
  end
  // the run needs well under 2 us; this only cuts a hung handshake short
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule

// [dv/iorm_chk.sv]
// checker: port timing relations of the i/o register bank
`timescale 1ns/100ps
module iorm_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // core access port
  input wire logic access_valid,
  input wire iorm_pkg::iorm_access_e access_kind,
  input wire logic [7:0] access_address,
  input wire logic [2:0] access_bit,
  input wire logic write_enable,
  input wire logic [7:0] write_data,
  input wire logic [7:0] read_data,
  input wire logic access_hit,
  // peripheral side
  input wire logic timer_overflow_event,
  input wire logic [7:0] cpu_status,
  input wire logic [7:0] port_b_output,
  input wire logic [7:0] nvm_control,
  input wire logic [7:0] watchdog_control,
  input wire logic [7:0] timer_irq_mask,
  input wire logic timer_irq_request
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic io_acc = access_valid && access_kind == iorm_pkg::IORM_ACC_IO;
  wire logic data_acc = access_valid && access_kind == iorm_pkg::IORM_ACC_DATA;
  wire logic bit_acc = access_valid && access_kind[1];
  // a set pulse in the same cycle beats the clearing write, so it is left out
  sequence s_flag_clear;
    io_acc && write_enable && access_address == 8'h38 && write_data[1] && !timer_overflow_event;
  endsequence
  sequence s_flag_set;
    timer_overflow_event && timer_irq_mask[1];
  endsequence
  a_data_window: assert property (data_acc && (access_address < 8'h20 || access_address > 8'h5F) |=>
    !access_hit && read_data == 8'h00) else $error("data address outside window answered");
  a_bit_limit: assert property (bit_acc && access_address > 8'h1F |=>
    !access_hit && $stable(watchdog_control)) else $error("bit op above 0x1F took effect");
  a_status_alias: assert property (data_acc && write_enable && access_address == 8'h5F |=>
    cpu_status == $past(write_data)) else $error("status write at data alias lost");
  a_status_read: assert property (io_acc && !write_enable && access_address == 8'h3F |=>
    access_hit && read_data == $past(cpu_status)) else $error("status read returned wrong value");
  a_flag_irq: assert property (s_flag_set |=> timer_irq_request) else $error("overflow did not raise request");
  a_flag_clear: assert property (s_flag_clear |=> !timer_irq_request) else $error("one written did not clear flag");
  a_nvm_fields: assert property (io_acc && write_enable && access_address == 8'h1C |=>
    nvm_control == ($past(write_data) & 8'h07)) else $error("nvm control fields wrong");
  a_bit_rmw: assert property (bit_acc && !access_kind[0] && access_address == 8'h18 |=>
    port_b_output == (($past(port_b_output) | (8'h01 << $past(access_bit))) & 8'h1F))
    else $error("bit set disturbed other bits");
  a_reserved_zero: assert property (io_acc && access_address == 8'h3E |=>
    !access_hit && read_data == 8'h00) else $error("reserved address answered");
endmodule
bind iorm_bank iorm_chk u_iorm_chk (.sys_clk(sys_clk), .reset(reset), .access_valid(access_valid),
  .access_kind(access_kind), .access_address(access_address), .access_bit(access_bit),
  .write_enable(write_enable), .write_data(write_data), .read_data(read_data), .access_hit(access_hit),
  .timer_overflow_event(timer_overflow_event), .cpu_status(cpu_status), .port_b_output(port_b_output),
  .nvm_control(nvm_control), .watchdog_control(watchdog_control), .timer_irq_mask(timer_irq_mask),
  .timer_irq_request(timer_irq_request));

// [dv/iorm_core_model.sv]
// partner model: cpu core issuing i/o, data-space and single-bit accesses
`timescale 1ns/100ps
module iorm_core_model (
  // clock
  input wire logic sys_clk,
  // access port
  output logic access_valid,
  output iorm_pkg::iorm_access_e access_kind,
  output logic [7:0] access_address,
  output logic [2:0] access_bit,
  output logic write_enable,
  output logic [7:0] write_data,
  input wire logic [7:0] read_data,
  input wire logic access_hit
);
  // one bit per mapped i/o address; a write anywhere else degrades to a read
  localparam logic [63:0] MAPPED = 64'hAF3C_0002_71C0_0000;
  initial begin
    access_valid = 1'b0;
    access_kind = iorm_pkg::IORM_ACC_IO;
    access_address = 8'h00;
    access_bit = 3'h0;
    write_enable = 1'b0;
    write_data = 8'h00;
  end
  task automatic access(input iorm_pkg::iorm_access_e kind, input logic [7:0] addr, input logic [2:0] bit_n,
                        input logic we, input logic [7:0] wd, output logic [7:0] rd, output logic hit);
    logic [7:0] io;
    io = (kind == iorm_pkg::IORM_ACC_DATA) ? addr - 8'h20 : addr;
    @(posedge sys_clk);
    access_valid <= 1'b1;
    access_kind <= kind;
    access_address <= addr;
    access_bit <= bit_n;
    write_enable <= we && MAPPED[io[5:0]];
    write_data <= wd;
    @(posedge sys_clk);
    access_valid <= 1'b0;
    #1;
    rd = read_data;
    hit = access_hit;
  endtask
endmodule

// [hw/iorm_bank.sv]
// module: i/o register bank decoding i/o, data-space and single-bit accesses
`timescale 1ns/100ps
module iorm_bank (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // core access port
  input wire logic access_valid,
  input wire iorm_pkg::iorm_access_e access_kind,
  input wire logic [7:0] access_address,
  input wire logic [2:0] access_bit,
  input wire logic write_enable,
  input wire logic [7:0] write_data,
  output logic [7:0] read_data,
  output logic access_hit,
  // core-side state updates
  input wire logic status_load,
  input wire logic [7:0] status_value,
  input wire logic stack_load,
  input wire logic [7:0] stack_value,
  // peripheral side
  input wire logic [4:0] port_b_pin_level,
  input wire logic timer_overflow_event,
  input wire logic ext_irq0_event,
  input wire logic external_reset_seen,
  input wire logic timer_count_load,
  input wire logic [7:0] timer_count_value,
  output logic [7:0] cpu_status,
  output logic [7:0] stack_pointer_low,
  output logic [7:0] port_b_output,
  output logic [7:0] port_b_direction,
  output logic [7:0] nvm_control,
  output logic [7:0] nvm_data,
  output logic [7:0] nvm_address,
  output logic [7:0] watchdog_control,
  output logic [7:0] timer_count,
  output logic [7:0] timer_control,
  output logic [7:0] mcu_control,
  output logic [7:0] timer_irq_mask,
  output logic [7:0] ext_irq_mask,
  output logic timer_irq_request,
  output logic ext_irq_request
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  wire is_data = (access_kind == iorm_pkg::IORM_ACC_DATA);
  wire is_bit_op = (access_kind == iorm_pkg::IORM_ACC_BIT_SET) || (access_kind == iorm_pkg::IORM_ACC_BIT_CLEAR);
  wire data_in_window = (access_address >= iorm_pkg::DATA_IO_BASE) && (access_address <= iorm_pkg::DATA_IO_LAST);
  wire [7:0] data_offset = access_address - iorm_pkg::DATA_IO_BASE;
  // data addresses sit 0x20 above the i/o address
  wire [5:0] io_address = is_data ? data_offset[5:0] : access_address[5:0];
  wire io_range_ok = is_data ? data_in_window : (access_address[7:6] == 2'b00);
  // single-bit operations above 0x1F are ignored outright
  wire bit_range_ok = io_address <= iorm_pkg::BIT_OP_LAST;
  wire access_ok = access_valid && io_range_ok && (!is_bit_op || bit_range_ok);

  function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_address);
    hit = (a == reg_address);
  endfunction

  wire sel_pins = hit(io_address, iorm_pkg::IO_PORT_B_PINS);
  wire sel_dir = hit(io_address, iorm_pkg::IO_PORT_B_DIRECTION);
  wire sel_out = hit(io_address, iorm_pkg::IO_PORT_B_OUTPUT);
  wire sel_nvm_ctl = hit(io_address, iorm_pkg::IO_NVM_CONTROL);
  wire sel_nvm_dat = hit(io_address, iorm_pkg::IO_NVM_DATA);
  wire sel_nvm_adr = hit(io_address, iorm_pkg::IO_NVM_ADDRESS);
  wire sel_wdt = hit(io_address, iorm_pkg::IO_WATCHDOG_CONTROL);
  wire sel_tcnt = hit(io_address, iorm_pkg::IO_TIMER_COUNT);
  wire sel_tctl = hit(io_address, iorm_pkg::IO_TIMER_CONTROL);
  wire sel_rcs = hit(io_address, iorm_pkg::IO_RESET_CAUSE_STATUS);
  wire sel_mcu = hit(io_address, iorm_pkg::IO_MCU_CONTROL);
  wire sel_tflg = hit(io_address, iorm_pkg::IO_TIMER_FLAGS);
  wire sel_tmsk = hit(io_address, iorm_pkg::IO_TIMER_IRQ_MASK);
  wire sel_eflg = hit(io_address, iorm_pkg::IO_EXT_IRQ_FLAGS);
  wire sel_emsk = hit(io_address, iorm_pkg::IO_EXT_IRQ_MASK);
  wire sel_sp = hit(io_address, iorm_pkg::IO_STACK_POINTER_LOW);
  wire sel_cpu_status = hit(io_address, iorm_pkg::IO_CPU_STATUS);

  wire mapped = sel_pins | sel_dir | sel_out | sel_nvm_ctl | sel_nvm_dat | sel_nvm_adr | sel_wdt | sel_tcnt |
    sel_tctl | sel_rcs | sel_mcu | sel_tflg | sel_tmsk | sel_eflg | sel_emsk | sel_sp | sel_cpu_status;

  //////////////////////////////////////////////////////////////////////////////
  // read path (current contents, also the base of a single-bit rewrite)

  logic [7:0] timer_flags;
  logic [7:0] ext_irq_flags;
  logic [7:0] reset_cause_status;
  logic [7:0] port_b_pins;

  // unmapped addresses and unused bits read as zero
  wire [7:0] current_value =
    ({8{sel_pins}} & port_b_pins) |
    ({8{sel_dir}} & port_b_direction) |
    ({8{sel_out}} & port_b_output) |
    ({8{sel_nvm_ctl}} & nvm_control) |
    ({8{sel_nvm_dat}} & nvm_data) |
    ({8{sel_nvm_adr}} & nvm_address) |
    ({8{sel_wdt}} & watchdog_control) |
    ({8{sel_tcnt}} & timer_count) |
    ({8{sel_tctl}} & timer_control) |
    ({8{sel_rcs}} & reset_cause_status) |
    ({8{sel_mcu}} & mcu_control) |
    ({8{sel_tflg}} & timer_flags) |
    ({8{sel_tmsk}} & timer_irq_mask) |
    ({8{sel_eflg}} & ext_irq_flags) |
    ({8{sel_emsk}} & ext_irq_mask) |
    ({8{sel_sp}} & stack_pointer_low) |
    ({8{sel_cpu_status}} & cpu_status);

  //////////////////////////////////////////////////////////////////////////////
  // write path

  wire [7:0] bit_onehot = 8'h01 << access_bit;
  // whole register is rewritten, so a flag read as one is written back as one
  wire [7:0] bit_op_value = (access_kind == iorm_pkg::IORM_ACC_BIT_SET) ? (current_value | bit_onehot) :
    (current_value & ~bit_onehot);
  wire do_write = access_ok && (is_bit_op || write_enable);
  // reserved addresses take no write; bit positions beyond each mask are dropped
  wire do_mapped_write = do_write && mapped;
  wire [7:0] wvalue = is_bit_op ? bit_op_value : write_data;

  wire w_dir = do_mapped_write && sel_dir;
  wire w_out = do_mapped_write && sel_out;
  wire w_nvm_ctl = do_mapped_write && sel_nvm_ctl;
  wire w_nvm_dat = do_mapped_write && sel_nvm_dat;
  wire w_nvm_adr = do_mapped_write && sel_nvm_adr;
  wire w_wdt = do_mapped_write && sel_wdt;
  wire w_tcnt = do_mapped_write && sel_tcnt;
  wire w_tctl = do_mapped_write && sel_tctl;
  wire w_rcs = do_mapped_write && sel_rcs;
  wire w_mcu = do_mapped_write && sel_mcu;
  wire w_tmsk = do_mapped_write && sel_tmsk;
  wire w_emsk = do_mapped_write && sel_emsk;
  wire w_sp = do_mapped_write && sel_sp;
  wire w_cpu_status = do_mapped_write && sel_cpu_status;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: three stages, a change counts once stages two and three agree

  logic [4:0] pin_meta;
  logic [4:0] pin_sync2;
  logic [4:0] pin_sync3;
  logic [4:0] pin_stable;

  always_ff @(posedge sys_clk) begin
    pin_meta <= port_b_pin_level;
    pin_sync2 <= pin_meta;
    pin_sync3 <= pin_sync2;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_stable <= 5'h00;
    end else if (pin_sync2 == pin_sync3) begin
      pin_stable <= pin_sync3;
    end
  end

  assign port_b_pins = {3'b000, pin_stable};

  //////////////////////////////////////////////////////////////////////////////
  // write-one-to-clear flag groups

  wire [7:0] timer_set = {8{timer_overflow_event}} & (8'h01 << iorm_pkg::TIMER_OVERFLOW_BIT);
  wire [7:0] ext_set = {8{ext_irq0_event}} & (8'h01 << iorm_pkg::EXT_IRQ0_BIT);

  iorm_flag u_timer_flags (
    .sys_clk(sys_clk),
    .reset(reset),
    .field_mask(iorm_pkg::MASK_TIMER_IRQ),
    .set_pulse(timer_set),
    .clear_write(do_mapped_write && sel_tflg),
    .clear_data(wvalue),
    .flags(timer_flags)
  );

  iorm_flag u_ext_flags (
    .sys_clk(sys_clk),
    .reset(reset),
    .field_mask(iorm_pkg::MASK_EXT_IRQ),
    .set_pulse(ext_set),
    .clear_write(do_mapped_write && sel_eflg),
    .clear_data(wvalue),
    .flags(ext_irq_flags)
  );

  //////////////////////////////////////////////////////////////////////////////
  // plain read/write registers, masked to their implemented bits

  // nvm strobes: read strobe bit 0, write enable bit 1, master write enable bit 2
  wire [7:0] nvm_ctl_mask = iorm_pkg::MASK_NVM_CONTROL;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      port_b_direction <= iorm_pkg::RESET_VALUE;
      port_b_output <= iorm_pkg::RESET_VALUE;
    end else begin
      if (w_dir) port_b_direction <= wvalue & iorm_pkg::MASK_PORT_B;
      if (w_out) port_b_output <= wvalue & iorm_pkg::MASK_PORT_B;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_control <= iorm_pkg::RESET_VALUE;
    end else if (w_nvm_ctl) begin
      nvm_control <= wvalue & nvm_ctl_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_data <= iorm_pkg::RESET_VALUE;
    end else if (w_nvm_dat) begin
      nvm_data <= wvalue;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_address <= iorm_pkg::RESET_VALUE;
    end else if (w_nvm_adr) begin
      nvm_address <= wvalue & iorm_pkg::MASK_NVM_ADDRESS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      watchdog_control <= iorm_pkg::RESET_VALUE;
    end else if (w_wdt) begin
      watchdog_control <= wvalue & iorm_pkg::MASK_WATCHDOG;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_control <= iorm_pkg::RESET_VALUE;
    end else if (w_tctl) begin
      timer_control <= wvalue & iorm_pkg::MASK_TIMER_CONTROL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mcu_control <= iorm_pkg::RESET_VALUE;
    end else if (w_mcu) begin
      mcu_control <= wvalue & iorm_pkg::MASK_MCU_CONTROL;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_irq_mask <= iorm_pkg::RESET_VALUE;
      ext_irq_mask <= iorm_pkg::RESET_VALUE;
    end else begin
      if (w_tmsk) timer_irq_mask <= wvalue & iorm_pkg::MASK_TIMER_IRQ;
      if (w_emsk) ext_irq_mask <= wvalue & iorm_pkg::MASK_EXT_IRQ;
    end
  end

  // bus writes win over the core's own updates in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stack_pointer_low <= iorm_pkg::RESET_VALUE;
    end else if (w_sp) begin
      stack_pointer_low <= wvalue;
    end else if (stack_load) begin
      stack_pointer_low <= stack_value;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_status <= iorm_pkg::RESET_VALUE;
    end else if (w_cpu_status) begin
      cpu_status <= wvalue;
    end else if (status_load) begin
      cpu_status <= status_value;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      timer_count <= iorm_pkg::RESET_VALUE;
    end else if (w_tcnt) begin
      timer_count <= wvalue;
    end else if (timer_count_load) begin
      timer_count <= timer_count_value;
    end
  end

  // reset cause: power-on marked at reset; external cause set by hardware, set wins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reset_cause_status <= iorm_pkg::RESET_CAUSE_RESET_VALUE;
    end else if (external_reset_seen) begin
      reset_cause_status <= reset_cause_status | (8'h01 << iorm_pkg::RESET_CAUSE_EXTERNAL_BIT);
    end else if (w_rcs) begin
      reset_cause_status <= wvalue & iorm_pkg::MASK_RESET_CAUSE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data register and request outputs

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      read_data <= iorm_pkg::RESET_VALUE;
      access_hit <= 1'b0;
    end else begin
      read_data <= access_ok ? current_value : iorm_pkg::RESET_VALUE;
      access_hit <= access_ok && mapped;
    end
  end

  assign timer_irq_request = |(timer_flags & timer_irq_mask);
  assign ext_irq_request = |(ext_irq_flags & ext_irq_mask);

endmodule

// [hw/iorm_flag.sv]
// module: one write-one-to-clear status flag group where a hardware set wins
`timescale 1ns/100ps
module iorm_flag (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // control
  input wire logic [7:0] field_mask,
  input wire logic [7:0] set_pulse,
  input wire logic clear_write,
  input wire logic [7:0] clear_data,
  // state
  output logic [7:0] flags
);

  logic [7:0] next_flags;

  // a set arriving with its clear is kept
  assign next_flags = field_mask & (set_pulse | (flags & ~({8{clear_write}} & clear_data)));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags <= iorm_pkg::RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

// [hw/iorm_pkg.sv]
// package: address map, field positions, reset values and access codes of the i/o register bank
//
// Operation
// - every i/o register also answers at data address i/o address plus 0x20
// - some status flags clear when a one is written into their position
// - bit set and bit clear rewrite the whole register; the flag registers at 0x38 and 0x3A lie beyond their reach
// - bit set and bit clear reach only i/o addresses 0x00 to 0x1F
package iorm_pkg;

  localparam logic [5:0] IO_PORT_B_PINS = 6'h16;
  localparam logic [5:0] IO_PORT_B_DIRECTION = 6'h17;
  localparam logic [5:0] IO_PORT_B_OUTPUT = 6'h18;
  localparam logic [5:0] IO_NVM_CONTROL = 6'h1C;
  localparam logic [5:0] IO_NVM_DATA = 6'h1D;
  localparam logic [5:0] IO_NVM_ADDRESS = 6'h1E;
  localparam logic [5:0] IO_WATCHDOG_CONTROL = 6'h21;
  localparam logic [5:0] IO_TIMER_COUNT = 6'h32;
  localparam logic [5:0] IO_TIMER_CONTROL = 6'h33;
  localparam logic [5:0] IO_RESET_CAUSE_STATUS = 6'h34;
  localparam logic [5:0] IO_MCU_CONTROL = 6'h35;
  localparam logic [5:0] IO_TIMER_FLAGS = 6'h38;
  localparam logic [5:0] IO_TIMER_IRQ_MASK = 6'h39;
  localparam logic [5:0] IO_EXT_IRQ_FLAGS = 6'h3A;
  localparam logic [5:0] IO_EXT_IRQ_MASK = 6'h3B;
  localparam logic [5:0] IO_STACK_POINTER_LOW = 6'h3D;
  localparam logic [5:0] IO_CPU_STATUS = 6'h3F;

  // data space window of the i/o space
  localparam logic [7:0] DATA_IO_BASE = 8'h20;
  localparam logic [7:0] DATA_IO_LAST = 8'h5F;
  // highest i/o address reachable by single-bit instructions
  localparam logic [5:0] BIT_OP_LAST = 6'h1F;

  // implemented bits of each register; the rest read as zero
  localparam logic [7:0] MASK_PORT_B = 8'h1F;
  localparam logic [7:0] MASK_NVM_CONTROL = 8'h07;
  localparam logic [7:0] MASK_NVM_ADDRESS = 8'h7F;
  localparam logic [7:0] MASK_WATCHDOG = 8'h1F;
  localparam logic [7:0] MASK_TIMER_CONTROL = 8'h07;
  localparam logic [7:0] MASK_RESET_CAUSE = 8'h03;
  localparam logic [7:0] MASK_MCU_CONTROL = 8'h33;
  localparam logic [7:0] MASK_TIMER_IRQ = 8'h02;
  localparam logic [7:0] MASK_EXT_IRQ = 8'h40;

  // field positions
  localparam int NVM_READ_STROBE_BIT = 0;
  localparam int NVM_WRITE_ENABLE_BIT = 1;
  localparam int NVM_MASTER_WRITE_ENABLE_BIT = 2;
  localparam int TIMER_OVERFLOW_BIT = 1;
  localparam int EXT_IRQ0_BIT = 6;
  localparam int RESET_CAUSE_POWER_BIT = 0;
  localparam int RESET_CAUSE_EXTERNAL_BIT = 1;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] RESET_CAUSE_RESET_VALUE = 8'h01;

  // access kinds issued by the core
  typedef enum logic [1:0] {
    IORM_ACC_IO = 2'b00,
    IORM_ACC_DATA = 2'b01,
    IORM_ACC_BIT_SET = 2'b10,
    IORM_ACC_BIT_CLEAR = 2'b11
  } iorm_access_e;

endpackage
